/* File: fbl_pkg.sv */
// Constants shared by the flash protection and verification block.
// Assumes a 16-bit command/data bus and a 100 MHz sys_clk.
package fbl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus widths and clock
   localparam int DATA_W       = 16;
   localparam int CLK_PERIOD_NS = 10;

   ////////////////////////////////////////////////////////////////////////
   // Command codes written on the data bus
   localparam logic [15:0] CMD_BC_SETUP   = 16'h00BC;
   localparam logic [15:0] CMD_CONFIRM    = 16'h00D0;
   localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
   localparam logic [15:0] CMD_LOCK       = 16'h0001;
   localparam logic [15:0] CMD_LOCKDOWN   = 16'h002F;
   localparam logic [15:0] CMD_OTP_SETUP  = 16'h00C0;
   localparam logic [15:0] CMD_ID_READ    = 16'h0090;
   localparam logic [15:0] CMD_STATUS     = 16'h0070;
   localparam logic [15:0] CMD_ARRAY      = 16'h00FF;
   localparam logic [15:0] CMD_CLR_STATUS = 16'h0050;

   ////////////////////////////////////////////////////////////////////////
   // Status word bit positions and reset value
   localparam int SW_READY    = 7;
   localparam int SW_ESUSP    = 6;
   localparam int SW_ERASEERR = 5;
   localparam int SW_PROGERR  = 4;
   localparam int SW_PSUSP    = 2;
   localparam int SW_LOCKERR  = 1;
   localparam logic [15:0] SW_RESET = 16'h0080;

   ////////////////////////////////////////////////////////////////////////
   // Identifier-space offsets inside a block or partition
   localparam logic [15:0] LOCK_OFS   = 16'h0002;
   localparam logic [15:0] OTP_BASE   = 16'h0080;
   localparam int OTP_WORDS  = 138;   // 2 lock regs + 2x4 + 16x8 words
   localparam int OTP_LR0    = 0;     // Lock register 0 word
   localparam int OTP_SMALL  = 1;     // First word of the two 64-bit blocks
   localparam int OTP_LR1    = 9;     // Lock register 1 word
   localparam int OTP_LARGE  = 10;    // First word of the 128-bit blocks
   localparam int SMALL_WPB  = 4;     // Words per 64-bit block
   localparam int LARGE_WPB  = 8;     // Words per 128-bit block

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int BC_TIME_NS  = 80;
   localparam int OTP_TIME_NS = 50;
   localparam int BC_CYC  = (BC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OTP_CYC = (OTP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [1:0] {PM_ARRAY, PM_STATUS, PM_ID} fbl_pmode_t;
   typedef enum logic [1:0] {LK_LOCK, LK_UNLOCK, LK_LDOWN} fbl_lkop_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_BC_SETUP, ST_LOCK_SETUP, ST_OTP_SETUP, ST_BC_RUN, ST_OTP_RUN
   } fbl_state_t;

endpackage : fbl_pkg

/* File: fbl_sync3.sv */
// Three-stage synchroniser for a level from a pin.
// Assumes one clock; output follows once stages two and three agree.
module fbl_sync3 #(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic pin_in,
   output logic      level_out
);
   logic s1;
   logic s2;
   logic s3;
   logic next_level;

   // Accept a change only when the last two stages agree
   always_comb begin
      next_level = (s2 == s3) ? s3 : level_out;
   end

   // Synchroniser chain and filtered level
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s1        <= RST_VAL;
         s2        <= RST_VAL;
         s3        <= RST_VAL;
         level_out <= RST_VAL;
      end else begin
         s1        <= pin_in;
         s2        <= s1;
         s3        <= s2;
         level_out <= next_level;
      end
   end
endmodule : fbl_sync3

/* File: fbl_ctrl.sv */
// Blank check, block lock state and OTP area of a partitioned NOR flash.
// Assumes the host writes commands one per cycle on wr_en and reads on rd_en.
// Behaviour
// - blank check one block, not while suspended
// - blank-check setup puts partition in status mode
// - status bit 7 low while checking
// - read-status command switches that partition
// - non-blank block sets status bits 7..5
// - only status reads during check, no suspend
// - reset locks all blocks, refuses program/erase
// - 0060h setup then 0001h/00D0h/002Fh confirm
// - ID read offset 02h gives lock bits
// - no lock change on busy block or program-suspend
// - lock during erase suspend applies at once
// - WP low keeps locked-down blocks locked
// - WP falling relocks all locked-down blocks
// - lock-down on unlocked block only marks it while WP high
// - lock-down attribute cleared only by reset
// - OTP holds 16+2 blocks, two lock registers
// - OTP program only clears bits per word
// - locked OTP block sets status bits 4, 1
// - OTP target out of range sets bit 4
// - OTP read in ID mode at partition base
// - reset gives array mode, status 0080h
module fbl_ctrl #(
   parameter int ADDR_W = 20,
   parameter int PART_W = 3,
   parameter int PB_W   = 5
) (
   input  wire logic                       sys_clk,
   input  wire logic                       nrst,
   input  wire logic                       wr_en,
   input  wire logic [ADDR_W-1:0]          wr_addr,
   input  wire logic [fbl_pkg::DATA_W-1:0] wr_data,
   input  wire logic                       rd_en,
   input  wire logic [ADDR_W-1:0]          rd_addr,
   output logic [fbl_pkg::DATA_W-1:0]      rd_data,
   output logic                            rd_valid,
   input  wire logic [fbl_pkg::DATA_W-1:0] array_data,
   input  wire logic [(1<<PB_W)-1:0]       array_blank,
   input  wire logic                       wp_n,
   input  wire logic                       prog_active,
   input  wire logic                       erase_active,
   input  wire logic                       prog_suspended,
   input  wire logic                       erase_suspended,
   input  wire logic [PB_W-1:0]            active_blk,
   input  wire logic                       pe_req,
   input  wire logic [PB_W-1:0]            pe_blk,
   output logic                            pe_grant,
   output logic                            pe_refuse,
   output logic [(1<<PB_W)-1:0]            block_locked,
   output logic [fbl_pkg::DATA_W-1:0]      status_word
);
   import fbl_pkg::*;

   localparam int NBLK  = 1 << PB_W;
   localparam int NPART = 1 << PART_W;
   localparam int OFS_W = ADDR_W - PB_W;

   // Refuse address splits that cannot hold the blocks or the OTP words
   if (PART_W > PB_W || OFS_W < 9) begin : g_bad_split
      $error("fbl_ctrl: address split cannot hold blocks or OTP words");
   end

   ////////////////////////////////////////////////////////////////////////
   // State
   fbl_state_t             state, next_state;
   logic [7:0]             cnt, next_cnt;
   logic [PB_W-1:0]        tgt_blk, next_tgt_blk;
   logic [7:0]             otp_idx, next_otp_idx;
   logic [DATA_W-1:0]      otp_data, next_otp_data;
   fbl_pmode_t             pmode [NPART];
   fbl_pmode_t             next_pmode [NPART];
   logic                   err6, err5, err4, err1;
   logic                   next_err6, next_err5, next_err4, next_err1;
   logic                   next_grant, next_refuse;
   logic [DATA_W-1:0]      next_rd_data, next_status;
   logic                   lock_op;
   fbl_lkop_t              lock_code;
   logic [NBLK-1:0]        lock_q, ldown_q;
   logic                   wp_level;
   logic                   wp_prot;
   logic                   otp_we;
   logic [DATA_W-1:0]      otp_mem [OTP_WORDS] = '{default: 16'hFFFF};

   // Write-protect pin enters through the synchroniser; low means protect
   fbl_sync3 #(.RST_VAL(1'b0)) u_wp_sync (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .pin_in    (wp_n),
      .level_out (wp_level)
   );
   assign wp_prot      = !wp_level;
   assign block_locked = lock_q;

   // Address fields
   logic [PB_W-1:0]   wr_blk, rd_blk;
   logic [PART_W-1:0] wr_part, rd_part;
   logic [OFS_W-1:0]  rd_ofs;
   logic [15:0]       wr_ofs;
   assign wr_blk  = wr_addr[ADDR_W-1 -: PB_W];
   assign rd_blk  = rd_addr[ADDR_W-1 -: PB_W];
   assign wr_part = wr_addr[ADDR_W-1 -: PART_W];
   assign rd_part = rd_addr[ADDR_W-1 -: PART_W];
   assign rd_ofs  = rd_addr[OFS_W-1:0];
   assign wr_ofs  = 16'(wr_addr[OFS_W-1:0]);

   // Lock bit guarding one OTP word; lock registers are never guarded
   function automatic logic otp_locked(input logic [7:0] idx);
      logic [7:0] rel;
      rel = 8'h00;
      if (idx >= 8'(OTP_LARGE)) begin
         rel = 8'((idx - 8'(OTP_LARGE)) / 8'(LARGE_WPB));
         return !otp_mem[OTP_LR1][rel[3:0]];
      end else if (idx >= 8'(OTP_SMALL) && idx < 8'(OTP_LR1)) begin
         rel = 8'((idx - 8'(OTP_SMALL)) / 8'(SMALL_WPB));
         return !otp_mem[OTP_LR0][rel[3:0]];
      end
      return 1'b0;
   endfunction : otp_locked

   ////////////////////////////////////////////////////////////////////////
   // Command sequencer, status word and read path
   always_comb begin
      logic [15:0] rel;
      logic        bad_range;
      logic        lk_refused;
      rel          = wr_ofs - OTP_BASE;
      bad_range    = (wr_ofs < OTP_BASE) || (rel >= 16'(OTP_WORDS));
      lk_refused   = prog_suspended ||
                     ((prog_active || erase_active) && active_blk == tgt_blk);
      next_state   = state;
      next_cnt     = cnt;
      next_tgt_blk = tgt_blk;
      next_otp_idx = otp_idx;
      next_otp_data = otp_data;
      next_pmode   = pmode;
      next_err6 = err6;
      next_err5 = err5;
      next_err4 = err4;
      next_err1 = err1;
      lock_op   = 1'b0;
      lock_code = LK_LOCK;
      otp_we    = 1'b0;
      unique case (state)
         ST_IDLE: if (wr_en) begin
            unique case (wr_data)
               CMD_BC_SETUP: begin
                  next_pmode[wr_part] = PM_STATUS;
                  if (prog_suspended || erase_suspended) begin
                     next_err5 = 1'b1;
                     next_err4 = 1'b1;
                  end else begin
                     next_tgt_blk = wr_blk;
                     next_state   = ST_BC_SETUP;
                  end
               end
               CMD_LOCK_SETUP: begin
                  next_pmode[wr_part] = PM_STATUS;
                  next_tgt_blk = wr_blk;
                  next_state   = ST_LOCK_SETUP;
               end
               CMD_OTP_SETUP: begin
                  next_pmode[wr_part] = PM_STATUS;
                  next_state = ST_OTP_SETUP;
               end
               CMD_STATUS:  next_pmode[wr_part] = PM_STATUS;
               CMD_ARRAY:   next_pmode[wr_part] = PM_ARRAY;
               CMD_ID_READ: next_pmode[wr_part] = PM_ID;
               CMD_CLR_STATUS: begin
                  next_err6 = 1'b0;
                  next_err5 = 1'b0;
                  next_err4 = 1'b0;
                  next_err1 = 1'b0;
               end
               default: ;
            endcase
         end
         ST_BC_SETUP: if (wr_en) begin
            if (wr_data == CMD_CONFIRM && wr_blk == tgt_blk) begin
               next_cnt   = 8'(BC_CYC - 1);
               next_state = ST_BC_RUN;
            end else begin
               next_err5  = 1'b1;
               next_err4  = 1'b1;
               next_state = ST_IDLE;
            end
         end
         ST_BC_RUN: begin
            // Only read-status is honoured; suspend and others drop
            if (wr_en && wr_data == CMD_STATUS)
               next_pmode[wr_part] = PM_STATUS;
            if (cnt == 8'h00) begin
               next_state = ST_IDLE;
               if (!array_blank[tgt_blk]) begin
                  next_err6 = 1'b1;
                  next_err5 = 1'b1;
               end
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         ST_LOCK_SETUP: if (wr_en) begin
            next_state   = ST_IDLE;
            next_tgt_blk = wr_blk;
            if (lk_refused) begin
               next_err1 = 1'b1;
            end else if (wr_data == CMD_LOCK) begin
               lock_op   = 1'b1;
               lock_code = LK_LOCK;
            end else if (wr_data == CMD_CONFIRM) begin
               lock_op   = 1'b1;
               lock_code = LK_UNLOCK;
            end else if (wr_data == CMD_LOCKDOWN) begin
               lock_op   = 1'b1;
               lock_code = LK_LDOWN;
            end else begin
               next_err5 = 1'b1;
               next_err4 = 1'b1;
            end
         end
         ST_OTP_SETUP: if (wr_en) begin
            if (bad_range) begin
               next_err4  = 1'b1;
               next_state = ST_IDLE;
            end else if (otp_locked(rel[7:0])) begin
               next_err4  = 1'b1;
               next_err1  = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_otp_idx  = rel[7:0];
               next_otp_data = wr_data;
               next_cnt      = 8'(OTP_CYC - 1);
               next_state    = ST_OTP_RUN;
            end
         end
         ST_OTP_RUN: begin
            // Not suspendable: all writes are dropped until done
            if (cnt == 8'h00) begin
               otp_we     = 1'b1;
               next_state = ST_IDLE;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
      endcase
      // Program/erase gate on the effective lock state
      next_grant  = pe_req && !lock_q[pe_blk];
      next_refuse = pe_req && lock_q[pe_blk];
      next_status = 16'h0000;
      next_status[SW_READY] = (next_state != ST_BC_RUN) &&
                              (next_state != ST_OTP_RUN);
      next_status[SW_ESUSP]    = next_err6 || erase_suspended;
      next_status[SW_ERASEERR] = next_err5;
      next_status[SW_PROGERR]  = next_err4;
      next_status[SW_PSUSP]    = prog_suspended;
      next_status[SW_LOCKERR]  = next_err1;
      next_rd_data = 16'h0000;
      unique case (pmode[rd_part])
         PM_ARRAY:  next_rd_data = array_data;
         PM_STATUS: next_rd_data = status_word;
         PM_ID: begin
            if (16'(rd_ofs) == LOCK_OFS)
               next_rd_data = {14'h0000, ldown_q[rd_blk], lock_q[rd_blk]};
            else if (16'(rd_ofs) >= OTP_BASE &&
                     16'(rd_ofs) < OTP_BASE + 16'(OTP_WORDS))
               next_rd_data = otp_mem[8'(16'(rd_ofs) - OTP_BASE)];
         end
      endcase
   end

   // Register the sequencer group; reset returns to array read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state       <= ST_IDLE;
         cnt         <= 8'h00;
         tgt_blk     <= '0;
         otp_idx     <= 8'h00;
         otp_data    <= 16'hFFFF;
         pmode       <= '{default: PM_ARRAY};
         err6        <= 1'b0;
         err5        <= 1'b0;
         err4        <= 1'b0;
         err1        <= 1'b0;
         pe_grant    <= 1'b0;
         pe_refuse   <= 1'b0;
         rd_data     <= 16'h0000;
         rd_valid    <= 1'b0;
         status_word <= SW_RESET;
      end else begin
         state       <= next_state;
         cnt         <= next_cnt;
         tgt_blk     <= next_tgt_blk;
         otp_idx     <= next_otp_idx;
         otp_data    <= next_otp_data;
         pmode       <= next_pmode;
         err6        <= next_err6;
         err5        <= next_err5;
         err4        <= next_err4;
         err1        <= next_err1;
         pe_grant    <= next_grant;
         pe_refuse   <= next_refuse;
         rd_data     <= next_rd_data;
         rd_valid    <= rd_en;
         status_word <= next_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // OTP storage: nonvolatile, so no reset; starts erased to ones
   // Bits only move from one to zero
   always_ff @(posedge sys_clk) begin
      if (otp_we)
         otp_mem[otp_idx] <= otp_mem[otp_idx] & otp_data;
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-block lock and lock-down state
   genvar gb;
   for (gb = 0; gb < NBLK; gb++) begin : g_blk
      logic next_lock, next_ldown, hit;
      always_comb begin
         hit        = lock_op && (tgt_blk == next_tgt_blk) &&
                      (next_tgt_blk == PB_W'(gb));
         next_lock  = lock_q[gb];
         next_ldown = ldown_q[gb];
         // Applies at once even to an erase-suspended block
         if (hit) begin
            unique case (lock_code)
               LK_LOCK:   next_lock = 1'b1;
               LK_UNLOCK: if (!(ldown_q[gb] && wp_prot))
                  next_lock = 1'b0;
               LK_LDOWN:  next_ldown = 1'b1;
            endcase
         end
         if (wp_prot && next_ldown)
            next_lock = 1'b1;
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            lock_q[gb]  <= 1'b1;
            ldown_q[gb] <= 1'b0;
         end else begin
            lock_q[gb]  <= next_lock;
            ldown_q[gb] <= next_ldown;
         end
      end

      a_ldown_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
         ldown_q[gb] |=> ldown_q[gb]) else $error("lock-down lost");
      a_wp_relock: assert property (@(posedge sys_clk) disable iff (!nrst)
         wp_prot && ldown_q[gb] |=> lock_q[gb])
         else $error("locked-down block open under WP");
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_bc_busy: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == ST_BC_SETUP && wr_en && wr_data == CMD_CONFIRM &&
      wr_blk == tgt_blk |=> !status_word[SW_READY] [*8] ##1
      status_word[SW_READY]) else $error("blank check busy span wrong");
   a_bc_fail: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == ST_BC_RUN && cnt == 8'h00 && !array_blank[tgt_blk]
      |=> status_word[7:5] == 3'b111) else $error("blank fail not shown");
   a_bc_mode: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == ST_IDLE && wr_en && wr_data == CMD_BC_SETUP
      |=> pmode[$past(wr_part)] == PM_STATUS)
      else $error("setup did not select status");
   a_bc_suspended: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == ST_IDLE && wr_en && wr_data == CMD_BC_SETUP &&
      (prog_suspended || erase_suspended) |=> state == ST_IDLE)
      else $error("blank check started while suspended");
   a_otp_lockerr: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == ST_OTP_SETUP && wr_en && wr_ofs >= OTP_BASE &&
      wr_ofs < OTP_BASE + 16'(OTP_WORDS) &&
      otp_locked(8'(wr_ofs - OTP_BASE))
      |=> status_word[SW_PROGERR] && status_word[SW_LOCKERR])
      else $error("locked OTP program not flagged");
   a_otp_range: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == ST_OTP_SETUP && wr_en && wr_ofs < OTP_BASE
      |=> status_word[SW_PROGERR] && state == ST_IDLE)
      else $error("out of range OTP not flagged");
   a_otp_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
      otp_we |=> (otp_mem[$past(otp_idx)] & ~$past(otp_mem[otp_idx]))
      == 16'h0000) else $error("OTP bit returned to one");
   a_pe_refuse: assert property (@(posedge sys_clk) disable iff (!nrst)
      pe_req && lock_q[pe_blk] |=> pe_refuse && !pe_grant)
      else $error("locked block granted");
   a_err_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
      err5 && !(state == ST_IDLE && wr_en && wr_data == CMD_CLR_STATUS)
      |=> err5) else $error("error bit dropped");
   a_lock_refused: assert property (@(posedge sys_clk) disable iff (!nrst)
      state == ST_LOCK_SETUP && wr_en && prog_suspended
      |=> status_word[SW_LOCKERR] && $stable(lock_q))
      else $error("lock change under program suspend");
endmodule : fbl_ctrl

/* File: fbl_array_model.sv */
// Main-array side model: blank map, moving data, suspend flags.
// Assumes the bench sets the blank map and the suspend request.
module fbl_array_model (
   input  wire logic        sys_clk,
   input  wire logic [31:0] blank_map,
   input  wire logic [1:0]  susp,
   output logic [15:0]      array_data,
   output logic [31:0]      array_blank,
   output logic             prog_suspended,
   output logic             erase_suspended
);
   timeunit 1ns;
   timeprecision 100ps;
   // Array data moves every cycle so stale reads never match
   logic [15:0] pattern = 16'h0000;
   always @(posedge sys_clk) pattern <= pattern + 16'h1357;
   assign array_data = pattern;
   // Blank map and both suspend flags as the bench commands
   assign array_blank = blank_map;
   assign prog_suspended = susp[0];
   assign erase_suspended = susp[1];
endmodule : fbl_array_model

/* File: test_flash_blank_lock_otp_control.sv */
// Self-checking bench for blank check, block lock and OTP control.
// Assumes fbl_pkg, fbl_ctrl and fbl_array_model compiled first.
module test_flash_blank_lock_otp_control;
   timeunit 1ns;
   timeprecision 100ps;
   import fbl_pkg::*;
   logic sys_clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic pe_req = 1'b0, wp_n = 1'b1;
   logic [1:0] susp = 2'b00, act = 2'b00;
   logic [19:0] wr_addr = 20'h0_0000, rd_addr = 20'h0_0000;
   logic [15:0] wr_data = 16'h0000, rd_data, status_word, array_data, d, e;
   logic [31:0] blank_map = 32'hFFFF_FFDF, array_blank, block_locked;
   logic [4:0] pe_blk = 5'h00, ablk = 5'h00;
   logic rd_valid, pe_grant, pe_refuse, prog_suspended, erase_suspended;
   logic [15:0] expq[$];
   int miscompares = 0, comparisons = 0;
   always #5 sys_clk = ~sys_clk;
   fbl_ctrl i_dut (.sys_clk, .nrst, .wr_en, .wr_addr, .wr_data, .rd_en,
      .rd_addr, .rd_data, .rd_valid, .array_data, .array_blank, .wp_n,
      .prog_active(act[0]), .erase_active(act[1]), .prog_suspended,
      .erase_suspended, .active_blk(ablk), .pe_req, .pe_blk, .pe_grant,
      .pe_refuse, .block_locked, .status_word);
   fbl_array_model i_far (.sys_clk, .blank_map, .susp, .array_data,
      .array_blank, .prog_suspended, .erase_suspended);
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   // One command write, held for exactly one sampling edge
   task automatic wr(input logic [4:0] b, input logic [14:0] o,
                     input logic [15:0] v);
      @(posedge sys_clk) #1;
      wr_en = 1'b1;
      wr_addr = {b, o};
      wr_data = v;
      @(posedge sys_clk) #1;
      wr_en = 1'b0;
   endtask : wr
   // Read with the expected word noted for the monitor
   task automatic rd(input logic [4:0] b, input logic [14:0] o,
                     input logic [15:0] x);
      expq.push_back(x);
      @(posedge sys_clk) #1;
      rd_en = 1'b1;
      rd_addr = {b, o};
      @(posedge sys_clk) #1;
      rd_en = 1'b0;
   endtask : rd
   task automatic lck(input logic [4:0] b, input logic [15:0] c);
      wr(b, 15'h0000, CMD_LOCK_SETUP);
      wr(b, 15'h0000, c);
      @(posedge sys_clk) #1;
   endtask : lck
   task automatic pe(input logic [4:0] b, input logic g);
      @(posedge sys_clk) #1;
      pe_req = 1'b1;
      pe_blk = b;
      @(posedge sys_clk) #1;
      pe_req = 1'b0;
      chk({pe_grant, pe_refuse}, {g, ~g});
   endtask : pe
   // Bounded wait for the ready bit; running out ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge sys_clk) #1;
      while (status_word[SW_READY] !== 1'b1 && n < 20) begin
         @(posedge sys_clk) #1;
         n++;
      end
      if (status_word[SW_READY] !== 1'b1) begin
         miscompares++;
         report_and_stop();
      end
   endtask : wait_ready
   task automatic otp(input logic [14:0] o, input logic [15:0] v);
      wr(5'h00, 15'h0000, CMD_OTP_SETUP);
      wr(5'h00, o, v);
      wait_ready();
   endtask : otp
   // Monitor takes the oldest expected word on every valid read
   always @(negedge sys_clk) begin
      if (rd_valid === 1'b1) begin
         if (expq.size() == 0) miscompares++;
         else chk(rd_data, expq.pop_front());
      end
   end
   initial begin
      void'($urandom(32'h0000_C429));
      repeat (5) @(posedge sys_clk) #1;
      nrst = 1'b1;
      chk(status_word, SW_RESET);
      chk(block_locked, 32'hFFFF_FFFF);
      pe(5'h03, 1'b0);
      lck(5'h03, CMD_CONFIRM);
      chk(block_locked[3], 1'b0);
      pe(5'h03, 1'b1);
      lck(5'h06, CMD_CONFIRM);
      lck(5'h06, CMD_LOCK);
      chk(block_locked[6], 1'b1);
      wr(5'h03, 15'h0000, CMD_ID_READ);
      rd(5'h03, LOCK_OFS[14:0], 16'h0000);
      lck(5'h03, CMD_LOCKDOWN);
      chk(block_locked[3], 1'b0);
      wp_n = 1'b0;
      repeat (6) @(posedge sys_clk) #1;
      chk(block_locked[3], 1'b1);
      lck(5'h03, CMD_CONFIRM);
      chk(block_locked[3], 1'b1);
      wr(5'h03, 15'h0000, CMD_ID_READ);
      rd(5'h03, LOCK_OFS[14:0], 16'h0003);
      wp_n = 1'b1;
      repeat (6) @(posedge sys_clk) #1;
      lck(5'h03, CMD_CONFIRM);
      chk(block_locked[3], 1'b0);
      wp_n = 1'b0;
      repeat (6) @(posedge sys_clk) #1;
      chk(block_locked[3], 1'b1);
      ablk = 5'h06;
      act = 2'b01;
      lck(5'h06, CMD_CONFIRM);
      act = 2'b10;
      lck(5'h06, CMD_CONFIRM);
      act = 2'b00;
      chk(block_locked[6], 1'b1);
      susp = 2'b10;
      lck(5'h07, CMD_CONFIRM);
      chk(block_locked[7], 1'b0);
      lck(5'h07, CMD_LOCK);
      chk(block_locked[7], 1'b1);
      susp = 2'b01;
      lck(5'h04, CMD_CONFIRM);
      chk(block_locked[4], 1'b1);
      wr(5'h05, 15'h0000, CMD_BC_SETUP);
      @(posedge sys_clk) #1;
      chk(status_word, 16'h00B6);
      susp = 2'b00;
      @(posedge sys_clk) #1;
      chk(status_word, 16'h00B2);
      wr(5'h05, 15'h0000, CMD_CLR_STATUS);
      @(posedge sys_clk) #1;
      chk(status_word, SW_RESET);
      wr(5'h05, 15'h0000, CMD_BC_SETUP);
      wr(5'h05, 15'h0000, CMD_CONFIRM);
      chk(status_word[SW_READY], 1'b0);
      lck(5'h04, CMD_CONFIRM);
      chk(block_locked[4], 1'b1);
      rd(5'h05, 15'h0000, 16'h0000);
      wait_ready();
      chk(status_word, 16'h00E0);
      wr(5'h09, 15'h0000, CMD_STATUS);
      rd(5'h09, 15'h0000, 16'h00E0);
      wr(5'h09, 15'h0000, CMD_CLR_STATUS);
      e = 16'hFFFF;
      for (int i = 0; i < 2; i++) begin
         d = 16'($urandom);
         e = e & d;
         otp(15'h008A, d);
         chk(status_word, SW_RESET);
         wr(5'h00, 15'h0000, CMD_ID_READ);
         rd(5'h00, 15'h008A, e);
      end
      otp(15'h0109, 16'h1234);
      otp(15'h0089, 16'hFFFE);
      otp(15'h008A, 16'h0000);
      chk(status_word, 16'h0092);
      wr(5'h00, 15'h0000, CMD_ID_READ);
      rd(5'h00, 15'h008A, e);
      rd(5'h00, 15'h0109, 16'h1234);
      wr(5'h00, 15'h0000, CMD_CLR_STATUS);
      otp(15'h010A, 16'h0000);
      chk(status_word, 16'h0090);
      wr(5'h09, 15'h0000, CMD_ARRAY);
      @(posedge sys_clk) #1;
      rd_en = 1'b1;
      rd_addr = {5'h09, 15'h0000};
      expq.push_back(array_data);
      @(posedge sys_clk) #1;
      rd_en = 1'b0;
      repeat (2) @(posedge sys_clk) #1;
      nrst = 1'b0;
      @(posedge sys_clk) #1;
      nrst = 1'b1;
      chk(status_word, SW_RESET);
      chk(block_locked, 32'hFFFF_FFFF);
      wr(5'h03, 15'h0000, CMD_ID_READ);
      rd(5'h03, LOCK_OFS[14:0], 16'h0001);
      repeat (3) @(posedge sys_clk) #1;
      if (expq.size() != 0) miscompares++;
      report_and_stop();
   end
endmodule : test_flash_blank_lock_otp_control
